// [logic/scp_defines.svh]
// offsets, field positions, reset values and timing counts of the synth control pin logic
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// ----------------------------------------------------------------------
// programming byte map (port buffer and active registers share it)
// ----------------------------------------------------------------------
`define SCP_NUM_BYTES 32
`define SCP_FREQ1_BYTE 0
`define SCP_FREQ2_BYTE 6
`define SCP_PHASE1_BYTE 12
`define SCP_PHASE2_BYTE 14
`define SCP_OSKRATE_BYTE 16
`define SCP_QDAC_BYTE 18
`define SCP_CTRL_BYTE 20
`define SCP_CHIRP_BYTE 22

// ----------------------------------------------------------------------
// control byte fields
// ----------------------------------------------------------------------
`define SCP_CTRL_UDDIR_BIT 0
`define SCP_CTRL_MODE_LSB 1
`define SCP_CTRL_OSKEN_BIT 3
`define SCP_CTRL_QEXT_BIT 4
`define SCP_MODE_SINGLE 2'h0
`define SCP_MODE_FSK 2'h1
`define SCP_MODE_BPSK 2'h2
`define SCP_MODE_CHIRP 2'h3

// ----------------------------------------------------------------------
// avalon word map
// ----------------------------------------------------------------------
`define SCP_AV_BUF_LAST 4'h7
`define SCP_AV_CMD 4'h8
`define SCP_CMD_UPDATE_BIT 0

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define SCP_BYTE_RESET 8'h00
`define SCP_UPD_PULSE_CYCLES 4'h8
`define SCP_FULL_SCALE 12'hFFF
`define SCP_ZERO_SCALE 12'h000
`define SCP_SER_LAST_BIT 4'hF

`endif

// [logic/scp_pkg.sv]
// types of the synth control pin logic
package scp_pkg;

  // avalon slave handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } scp_bus_e;

  // keying modes, decoded one-hot from the control byte
  typedef enum logic [3:0] {
    MD_SINGLE = 4'b0001,
    MD_FSK = 4'b0010,
    MD_BPSK = 4'b0100,
    MD_CHIRP = 4'b1000
  } scp_mode_e;

  typedef logic [31:0][7:0] scp_bytes_t;

  // parallel programming pins, sampled together
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
    logic rdN;
  } scp_par_s;

  // core domain state
  typedef struct packed {
    scp_bytes_t portBuf;
    scp_bytes_t act;
    scp_bus_e busSt;
    logic waitReq;
    logic [31:0] readData;
    logic [1:0] spSync;
    logic [1:0] keySync;
    logic [1:0] oskSync;
    logic [1:0] udSync;
    logic [1:0] wrSync;
    logic udPrev;
    logic wrPrev;
    scp_par_s par1;
    scp_par_s par2;
    logic [2:0] togSync;
    logic [3:0] pulseCnt;
    logic udOut;
    logic udOe;
    logic [7:0] rateCnt;
    logic [11:0] amp;
    logic [47:0] sweep;
    logic [7:0] dataOut;
    logic dataOe;
    logic [47:0] freqOut;
    logic [13:0] phaseOut;
    logic [11:0] ampOut;
    logic [11:0] quadOut;
  } scp_core_s;

  // serial shifter, cleared by chip select, serial recovery or reset
  typedef struct packed {
    logic [15:0] shift;
    logic [3:0] cnt;
  } scp_ser_s;

  // completed serial word and its event toggle, cleared by reset only
  typedef struct packed {
    logic [15:0] word;
    logic tog;
  } scp_serout_s;

endpackage

// [logic/scp_synth_control.sv]
// pin-level control logic of the quadrature synthesizer with avalon register access
//
// Overview of operation
// - update transfer pin direction follows a bit in the control byte
// - input direction: each rising edge copies port buffers into active registers
// - output direction (default): eight-cycle high pulse on each internal update
// - serial mode captures serial data on the rising serial clock edge
// - parallel write strobe loads data into port buffers only
// - parallel read strobe drives back the active programming registers
// - serial mode: read pin is chip select; device responds only while low
// - frequency-shift mode: pin low gives first word, high gives second word
// - phase-shift mode: pin low gives first offset, high gives second offset
// - chirp mode: pin high freezes the sweep accumulator, low runs it
// - shaped keying pin is ignored unless enabled in the control byte
// - shaped keying ramps amplitude up on high, down on low, at programmed rate
// - quadrature converter can take programmed 12-bit data instead of sine samples
// - interface select low chooses serial mode, high chooses parallel mode
// - master reset initialises the port and loads do-nothing defaults
// - serial recovery input clears only serial state, not register contents
`include "scp_defines.svh"

module scp_synth_control (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wrSclk,
  input wire logic rdCsN,
  input wire logic serialDataIn,
  input wire logic ioReset,
  input wire logic spSelect,
  input wire scp_pkg::scp_par_s parPins,
  output logic [7:0] parDataOut,
  output logic parDataOe,
  input wire logic keyingSelectPin,
  input wire logic shapedKeyingPin,
  input wire logic updateTransferIn,
  output logic updateTransferOut,
  output logic updateTransferOe,
  input wire logic [11:0] sineSample,
  output logic [47:0] freqWord,
  output logic [13:0] phaseWord,
  output logic [11:0] ampScale,
  output logic [11:0] quadratureConverterOutput,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // gathers a little-endian multi-byte field out of the byte map
  function automatic logic [47:0] pick(input scp_pkg::scp_bytes_t r, input int base,
                                       input int len);
    logic [47:0] v;
    v = 48'h0;
    for (int i = 0; i < len; i++) begin
      v[8*i +: 8] = r[base + i];
    end
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // serial link domain, clocked by the shared write/serial clock pin
  // ----------------------------------------------------------------------
  scp_pkg::scp_ser_s ser_ff;
  scp_pkg::scp_ser_s nxt_ser;
  scp_pkg::scp_serout_s serOut_ff;
  scp_pkg::scp_serout_s nxt_serOut;
  logic serRst;

  // chip select high, recovery input or master reset drops a half-shifted word
  // the clear is asynchronous because the serial clock stops between frames
  assign serRst = sys_rst | ioReset | rdCsN;

  // shift one bit per rising serial clock; every 16 bits hand over a pair
  // the count wraps by itself, so no extra edge is needed to close a word
  always_comb begin
    nxt_ser = ser_ff;
    nxt_serOut = serOut_ff;
    nxt_ser.shift = {ser_ff.shift[14:0], serialDataIn};
    nxt_ser.cnt = ser_ff.cnt + 4'h1;
    if (ser_ff.cnt == `SCP_SER_LAST_BIT) begin
      nxt_serOut.word = nxt_ser.shift;
      nxt_serOut.tog = ~serOut_ff.tog;
      nxt_ser.cnt = 4'h0;
    end
  end

  // shifter state, cleared asynchronously by serRst
  always_ff @(posedge wrSclk or posedge serRst) begin
    if (serRst) begin
      ser_ff <= '0;
    end else begin
      ser_ff <= nxt_ser;
    end
  end

  // handed-over word only resets with the master reset, so recovery cannot fake an event
  always_ff @(posedge wrSclk or posedge sys_rst) begin
    if (sys_rst) begin
      serOut_ff <= '0;
    end else begin
      serOut_ff <= nxt_serOut;
    end
  end

  // ----------------------------------------------------------------------
  // core domain
  // ----------------------------------------------------------------------
  scp_pkg::scp_core_s cur_ff;
  scp_pkg::scp_core_s nxt_cur;
  scp_pkg::scp_mode_e modeSt;
  logic [7:0] ctrlByte;
  logic dirIn;
  logic oskEn;
  logic qExt;
  logic parMode;
  logic updateNow;
  logic pulseStart;
  logic togEvent;
  logic [4:0] byteIdx;
  logic [11:0] ampTarget;
  // byte-map fields gathered once, so the selections below stay plain part-selects
  logic [47:0] freq1Word;
  logic [47:0] freq2Word;
  logic [47:0] chirpStep;
  logic [15:0] phase1Word;
  logic [15:0] phase2Word;
  logic [15:0] qdacWord;

  always_comb begin
    nxt_cur = cur_ff;
    updateNow = 1'b0;
    pulseStart = 1'b0;
    byteIdx = 5'h0;
    ampTarget = `SCP_ZERO_SCALE;
    modeSt = scp_pkg::MD_SINGLE;

    // field views of the active registers, cut to width on purpose
    freq1Word = pick(cur_ff.act, `SCP_FREQ1_BYTE, 6);
    freq2Word = pick(cur_ff.act, `SCP_FREQ2_BYTE, 6);
    chirpStep = pick(cur_ff.act, `SCP_CHIRP_BYTE, 2);
    phase1Word = 16'(pick(cur_ff.act, `SCP_PHASE1_BYTE, 2));
    phase2Word = 16'(pick(cur_ff.act, `SCP_PHASE2_BYTE, 2));
    qdacWord = 16'(pick(cur_ff.act, `SCP_QDAC_BYTE, 2));

    // two-stage synchronisers for every pin that arrives unclocked
    nxt_cur.spSync = {cur_ff.spSync[0], spSelect};
    nxt_cur.keySync = {cur_ff.keySync[0], keyingSelectPin};
    nxt_cur.oskSync = {cur_ff.oskSync[0], shapedKeyingPin};
    nxt_cur.udSync = {cur_ff.udSync[0], updateTransferIn};
    nxt_cur.wrSync = {cur_ff.wrSync[0], wrSclk};
    nxt_cur.par1 = parPins;
    nxt_cur.par2 = cur_ff.par1;
    // the word itself is read only once its toggle has crossed, so it is stable
    nxt_cur.togSync = {cur_ff.togSync[1:0], serOut_ff.tog};
    nxt_cur.udPrev = cur_ff.udSync[1];
    nxt_cur.wrPrev = cur_ff.wrSync[1];
    togEvent = cur_ff.togSync[2] ^ cur_ff.togSync[1];

    ctrlByte = cur_ff.act[`SCP_CTRL_BYTE];
    dirIn = ctrlByte[`SCP_CTRL_UDDIR_BIT];
    oskEn = ctrlByte[`SCP_CTRL_OSKEN_BIT];
    qExt = ctrlByte[`SCP_CTRL_QEXT_BIT];
    // mode select is quasi-static; switching it mid-transfer loses that transfer
    parMode = cur_ff.spSync[1];

    // avalon slave: one wait cycle, then waitrequest low for exactly one edge
    // trade-off: a fixed latency keeps the slave small, at one idle cycle per access
    case (cur_ff.busSt)
      scp_pkg::BUS_IDLE: begin
        nxt_cur.waitReq = 1'b1;
        if (avs_read || avs_write) begin
          nxt_cur.busSt = scp_pkg::BUS_ACK;
          nxt_cur.waitReq = 1'b0;
          nxt_cur.readData = 32'h0;
          if (avs_address <= `SCP_AV_BUF_LAST) begin
            for (int b = 0; b < 4; b++) begin
              byteIdx = {avs_address[2:0], 2'(b)};
              nxt_cur.readData[8*b +: 8] = cur_ff.act[byteIdx];
            end
          end else if (avs_address == `SCP_AV_CMD) begin
            nxt_cur.readData = {16'h0, cur_ff.amp, cur_ff.udOut, cur_ff.oskSync[1],
                                cur_ff.keySync[1], dirIn};
          end
        end
      end
      scp_pkg::BUS_ACK: begin
        nxt_cur.busSt = scp_pkg::BUS_IDLE;
        nxt_cur.waitReq = 1'b1;
        if (avs_write && avs_address <= `SCP_AV_BUF_LAST) begin
          for (int b = 0; b < 4; b++) begin
            byteIdx = {avs_address[2:0], 2'(b)};
            if (avs_byteenable[b]) begin
              nxt_cur.portBuf[byteIdx] = avs_writedata[8*b +: 8];
            end
          end
        end else if (avs_write && avs_address == `SCP_AV_CMD && avs_byteenable[0]) begin
          if (avs_writedata[`SCP_CMD_UPDATE_BIT]) begin
            updateNow = 1'b1;
            pulseStart = ~dirIn;
          end
        end
      end
      default: begin
        nxt_cur.busSt = scp_pkg::BUS_IDLE;
        nxt_cur.waitReq = 1'b1;
      end
    endcase

    // parallel write strobe: rising edge lands in the port buffer only
    if (parMode && cur_ff.wrSync[1] && !cur_ff.wrPrev && !cur_ff.par2.addr[5]) begin
      nxt_cur.portBuf[cur_ff.par2.addr[4:0]] = cur_ff.par2.data;
    end

    // serial pair: address byte then data byte; read requests are not served
    // an address above the map is dropped as well, as on the parallel pins
    if (!parMode && togEvent && !serOut_ff.word[15] && !serOut_ff.word[13]) begin
      nxt_cur.portBuf[serOut_ff.word[12:8]] = serOut_ff.word[7:0];
    end

    // external update edge only counts while the pin is an input
    if (dirIn && cur_ff.udSync[1] && !cur_ff.udPrev) begin
      updateNow = 1'b1;
    end
    if (updateNow) begin
      nxt_cur.act = cur_ff.portBuf;
    end

    // update pulse, eight cycles high, restarted by a new update
    // a retrigger restarts the count instead of queueing a second pulse
    if (pulseStart) begin
      nxt_cur.pulseCnt = `SCP_UPD_PULSE_CYCLES;
    end else if (cur_ff.pulseCnt != 4'h0) begin
      nxt_cur.pulseCnt = cur_ff.pulseCnt - 4'h1;
    end
    nxt_cur.udOut = (nxt_cur.pulseCnt != 4'h0);
    nxt_cur.udOe = ~nxt_cur.act[`SCP_CTRL_BYTE][`SCP_CTRL_UDDIR_BIT];

    // parallel readback drives the active registers, not the buffers
    // it follows the synced pins, so it lags the strobe by about three cycles
    nxt_cur.dataOe = parMode && !cur_ff.par2.rdN;
    nxt_cur.dataOut = cur_ff.par2.addr[5] ? 8'h00 : cur_ff.act[cur_ff.par2.addr[4:0]];

    // shaped keying: one amplitude step per rate period; rate zero steps every cycle
    // limitation: the ramp is linear, one step per period, 4095 steps end to end
    if (!oskEn) begin
      nxt_cur.amp = `SCP_FULL_SCALE;
      nxt_cur.rateCnt = 8'h00;
    end else begin
      ampTarget = cur_ff.oskSync[1] ? `SCP_FULL_SCALE : `SCP_ZERO_SCALE;
      if (cur_ff.rateCnt == 8'h00) begin
        nxt_cur.rateCnt = cur_ff.act[`SCP_OSKRATE_BYTE];
        if (cur_ff.amp < ampTarget) begin
          nxt_cur.amp = cur_ff.amp + 12'h001;
        end else if (cur_ff.amp > ampTarget) begin
          nxt_cur.amp = cur_ff.amp - 12'h001;
        end
      end else begin
        nxt_cur.rateCnt = cur_ff.rateCnt - 8'h01;
      end
    end

    // decode the keying mode field
    case (ctrlByte[`SCP_CTRL_MODE_LSB +: 2])
      `SCP_MODE_FSK: modeSt = scp_pkg::MD_FSK;
      `SCP_MODE_BPSK: modeSt = scp_pkg::MD_BPSK;
      `SCP_MODE_CHIRP: modeSt = scp_pkg::MD_CHIRP;
      default: modeSt = scp_pkg::MD_SINGLE;
    endcase

    // frequency and phase selection; sweep wraps freely, as an accumulator does
    // software keeps the chirp step small enough that the wrap is never reached
    nxt_cur.freqOut = freq1Word;
    nxt_cur.phaseOut = phase1Word[13:0];
    nxt_cur.sweep = 48'h0;
    case (modeSt)
      scp_pkg::MD_FSK: begin
        if (cur_ff.keySync[1]) begin
          nxt_cur.freqOut = freq2Word;
        end
      end
      scp_pkg::MD_BPSK: begin
        if (cur_ff.keySync[1]) begin
          nxt_cur.phaseOut = phase2Word[13:0];
        end
      end
      scp_pkg::MD_CHIRP: begin
        nxt_cur.sweep = cur_ff.sweep;
        if (!cur_ff.keySync[1]) begin
          nxt_cur.sweep = cur_ff.sweep + chirpStep;
        end
        nxt_cur.freqOut = freq1Word + cur_ff.sweep;
      end
      default: begin
        nxt_cur.sweep = 48'h0;
      end
    endcase

    nxt_cur.ampOut = cur_ff.amp;
    // programmed data replaces sine samples when selected
    nxt_cur.quadOut = qExt ? qdacWord[11:0] : sineSample;
  end

  // ----------------------------------------------------------------------
  // core registers
  // ----------------------------------------------------------------------
  // master reset: all bytes do-nothing, update pin an output, bus waiting
  // the fields set after the clear are constants only, so reset stays clean
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '0;
      cur_ff.busSt <= scp_pkg::BUS_IDLE;
      cur_ff.waitReq <= 1'b1;
      cur_ff.udOe <= 1'b1;
      cur_ff.par1.rdN <= 1'b1;
      cur_ff.par2.rdN <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, straight from flip-flops
  // ----------------------------------------------------------------------
  assign avs_readdata = cur_ff.readData;
  assign avs_waitrequest = cur_ff.waitReq;
  assign parDataOut = cur_ff.dataOut;
  assign parDataOe = cur_ff.dataOe;
  assign updateTransferOut = cur_ff.udOut;
  assign updateTransferOe = cur_ff.udOe;
  assign freqWord = cur_ff.freqOut;
  assign phaseWord = cur_ff.phaseOut;
  assign ampScale = cur_ff.ampOut;
  assign quadratureConverterOutput = cur_ff.quadOut;

endmodule

// [tb/scp_synth_control_monitor.sv]
// port assertions for the synth control pin logic
module scp_mon (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic spSelect,
  input wire scp_pkg::scp_par_s parPins,
  input wire logic parDataOe,
  input wire logic updateTransferOut,
  input wire logic updateTransferOe,
  input wire logic [11:0] ampScale,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // accepted command write that asks for an update
  sequence cmdUpd;
    avs_write && !avs_waitrequest && avs_address == 4'h8 && avs_writedata[0] && avs_byteenable[0];
  endsequence
  sequence pulse8;
    updateTransferOut [*8] ##1 !updateTransferOut;
  endsequence
  // retrigger would stretch the pulse, so the bench never retriggers
  upd_len_a: assert property ($rose(updateTransferOut) |-> pulse8)
    else $error("update pulse not eight cycles");
  upd_start_a: assert property (cmdUpd ##0 updateTransferOe |-> ##[1:2] updateTransferOut)
    else $error("update pulse missing");
  upd_dir_a: assert property (cmdUpd ##0 !updateTransferOe |=> !updateTransferOut [*3])
    else $error("pulse driven in input direction");
  bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  bus_idle_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without request");
  unmap_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 4'h8
      |-> avs_readdata == 32'h0)
    else $error("unmapped word not zero");
  rd_hold_a: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data moved between answers");
  par_on_a: assert property ((spSelect && !parPins.rdN) [*6] |-> parDataOe)
    else $error("readback not driven");
  par_off_a: assert property (parPins.rdN [*5] |-> !parDataOe)
    else $error("readback driven after strobe");
  ser_no_oe_a: assert property ((!spSelect) [*5] |-> !parDataOe)
    else $error("data bus driven in serial mode");
  amp_step_a: assert property ($changed(ampScale) && ampScale != 12'hFFF
      |-> ampScale == $past(ampScale) + 12'h001 || ampScale == $past(ampScale) - 12'h001)
    else $error("amplitude jumped");
endmodule
bind scp_synth_control scp_mon i_scp_mon (.core_clk(core_clk), .sys_rst(sys_rst),
  .spSelect(spSelect), .parPins(parPins), .parDataOe(parDataOe),
  .updateTransferOut(updateTransferOut), .updateTransferOe(updateTransferOe),
  .ampScale(ampScale), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// [tb/scp_ctl_model.sv]
// model of the external controller on the programming pins
module scp_ctl_model (
  input wire logic core_clk,
  input wire logic [7:0] parDataOut,
  input wire logic parDataOe,
  output logic wrSclk,
  output logic rdCsN,
  output logic serialDataIn,
  output logic ioReset,
  output scp_pkg::scp_par_s parPins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] adr;
  logic [7:0] dat;
  // read strobe and chip select share one pin
  assign parPins = '{addr: adr, data: dat, rdN: rdCsN};
  // idle pins at time zero
  initial begin
    wrSclk = 1'b0;
    rdCsN = 1'b1;
    serialDataIn = 1'b0;
    ioReset = 1'b0;
    adr = 6'h00;
    dat = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // strobe loads the port buffer; address and data held around it
  task automatic parWrite(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    adr <= a;
    dat <= d;
    cyc(4);
    wrSclk <= 1'b1;
    cyc(4);
    wrSclk <= 1'b0;
    cyc(4);
    dat <= ~d; // released bus must not show the old value
  endtask
  // readback byte counts only while the device drives the bus
  task automatic parRead(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    adr <= a;
    rdCsN <= 1'b0;
    cyc(6);
    d = parDataOe === 1'b1 ? parDataOut : 8'hXX;
    rdCsN <= 1'b1;
    cyc(6);
  endtask
  // 30 ns serial clock, msb first, running only inside the frame
  task automatic ser(input int n, input logic [15:0] w, input logic cs);
    rdCsN <= cs;
    #15;
    for (int i = 15; i > 15 - n; i--) begin
      serialDataIn <= w[i];
      #15 wrSclk <= 1'b1;
      #15 wrSclk <= 1'b0;
    end
    serialDataIn <= ~w[16 - n];
    if (n == 16) rdCsN <= 1'b1;
    #15;
  endtask
  task automatic ioClear();
    @(posedge core_clk);
    ioReset <= 1'b1;
    cyc(2);
    ioReset <= 1'b0;
  endtask
endmodule

// [tb/tb_scp_synth_control.sv]
// testbench of the synth control pin logic
module tb_scp_synth_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic spSelect = 1'b0;
  logic keyingSelectPin = 1'b0;
  logic shapedKeyingPin = 1'b0;
  logic updateTransferIn = 1'b0;
  logic [11:0] sineSample = 12'h5A5;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic wrSclk, rdCsN, serialDataIn, ioReset, parDataOe, updateTransferOut, updateTransferOe;
  logic [7:0] parDataOut, pb;
  logic [47:0] freqWord, f0;
  logic [13:0] phaseWord;
  logic [11:0] ampScale, quadratureConverterOutput;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest;
  scp_pkg::scp_par_s parPins;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int k = 0;
  scp_synth_control i_scp_synth_control (.core_clk(core_clk), .sys_rst(sys_rst),
    .wrSclk(wrSclk), .rdCsN(rdCsN), .serialDataIn(serialDataIn), .ioReset(ioReset),
    .spSelect(spSelect), .parPins(parPins), .parDataOut(parDataOut), .parDataOe(parDataOe),
    .keyingSelectPin(keyingSelectPin), .shapedKeyingPin(shapedKeyingPin),
    .updateTransferIn(updateTransferIn), .updateTransferOut(updateTransferOut),
    .updateTransferOe(updateTransferOe), .sineSample(sineSample), .freqWord(freqWord),
    .phaseWord(phaseWord), .ampScale(ampScale),
    .quadratureConverterOutput(quadratureConverterOutput), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  scp_ctl_model i_scp_ctl_model (.core_clk(core_clk), .parDataOut(parDataOut),
    .parDataOe(parDataOe), .wrSclk(wrSclk), .rdCsN(rdCsN), .serialDataIn(serialDataIn),
    .ioReset(ioReset), .parPins(parPins));
  // 100 ns system clock
  always #50 core_clk = ~core_clk;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic setB(input int b, input logic [7:0] v);
    av(1'b1, 4'(b / 4), 32'(v) << (8 * (b % 4)), 4'h1 << (b % 4));
  endtask
  task automatic upd();
    av(1'b1, 4'h8, 32'h1, 4'h1);
  endtask
  // --------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------
  initial begin
    cyc(12);
    sys_rst <= 1'b0;
    cyc(4);
    chk(updateTransferOe, 1'b1);
    chk(ampScale, 12'hFFF);
    chk(freqWord, 48'h0);
    chk(quadratureConverterOutput, 12'h5A5);
    $display("test reset finished");
    av(1'b1, 4'h0, 32'h44332211, 4'hF);
    av(1'b0, 4'h0, 32'h0, 4'h0);
    chk(rd, 32'h0);
    av(1'b1, 4'h9, 32'hFFFFFFFF, 4'hF);
    av(1'b0, 4'h9, 32'h0, 4'h0);
    chk(rd, 32'h0);
    upd();
    repeat (12) begin
      @(posedge core_clk);
      k += (updateTransferOut === 1'b1);
    end
    chk(k, 8);
    av(1'b0, 4'h0, 32'h0, 4'h0);
    chk(rd, 32'h44332211);
    $display("test update finished");
    spSelect <= 1'b1;
    i_scp_ctl_model.parWrite(6'h08, 8'h77);
    i_scp_ctl_model.parRead(6'h08, pb);
    chk(pb, 8'h00);
    upd();
    i_scp_ctl_model.parRead(6'h08, pb);
    chk(pb, 8'h77);
    $display("test parallel finished");
    // a partial word cut by the recovery input must not pair with the next one
    spSelect <= 1'b0;
    cyc(4);
    i_scp_ctl_model.ser(16, 16'h0C34, 1'b0);
    i_scp_ctl_model.ser(16, 16'h0E5A, 1'b1);
    i_scp_ctl_model.ser(8, 16'h0FFF, 1'b0);
    i_scp_ctl_model.ioClear();
    i_scp_ctl_model.ser(16, 16'h0D12, 1'b0);
    cyc(6);
    upd();
    cyc(4);
    chk(phaseWord, 14'h1234);
    chk(freqWord, 48'h44332211);
    av(1'b0, 4'h3, 32'h0, 4'h0);
    chk(rd, 32'h00001234);
    $display("test serial finished");
    av(1'b1, 4'h1, 32'h66550000, 4'hC);
    av(1'b1, 4'h3, 32'h0ABC0000, 4'hC);
    av(1'b1, 4'h5, 32'h00010000, 4'hC);
    setB(20, 8'h02);
    upd();
    cyc(6);
    chk(freqWord, 48'h44332211);
    keyingSelectPin <= 1'b1;
    cyc(6);
    chk(freqWord, 48'h776655);
    keyingSelectPin <= 1'b0;
    setB(20, 8'h04);
    upd();
    cyc(6);
    chk(phaseWord, 14'h1234);
    keyingSelectPin <= 1'b1;
    cyc(6);
    chk(phaseWord, 14'h0ABC);
    setB(20, 8'h06);
    upd();
    cyc(10);
    chk(freqWord, 48'h44332211);
    keyingSelectPin <= 1'b0;
    cyc(6);
    f0 = freqWord;
    cyc(5);
    chk(freqWord, f0 + 48'h5);
    $display("test keying finished");
    setB(16, 8'h03);
    setB(20, 8'h08);
    upd();
    cyc(8);
    f0 = ampScale;
    cyc(80);
    chk(f0 - ampScale, 20);
    shapedKeyingPin <= 1'b1;
    cyc(8);
    f0 = ampScale;
    cyc(40);
    chk(ampScale - f0, 10);
    shapedKeyingPin <= 1'b0;
    setB(20, 8'h00);
    upd();
    cyc(20);
    chk(ampScale, 12'hFFF);
    $display("test shaping finished");
    av(1'b1, 4'h4, 32'h03210000, 4'hC);
    setB(20, 8'h10);
    upd();
    cyc(4);
    chk(quadratureConverterOutput, 12'h321);
    setB(20, 8'h01);
    upd();
    cyc(4);
    chk(updateTransferOe, 1'b0);
    av(1'b1, 4'h0, 32'h000000AB, 4'h1);
    cyc(4);
    av(1'b0, 4'h0, 32'h0, 4'h0);
    chk(rd, 32'h44332211);
    updateTransferIn <= 1'b1;
    cyc(6);
    av(1'b0, 4'h0, 32'h0, 4'h0);
    chk(rd, 32'h443322AB);
    updateTransferIn <= 1'b0;
    setB(20, 8'h00);
    upd();
    cyc(4);
    chk(updateTransferOe, 1'b1);
    av(1'b0, 4'h8, 32'h0, 4'h0);
    chk(rd, 32'h0000FFF0);
    $display("test direction finished");
    give_verdict();
  end
endmodule
